// [tb_top.sv]
// Self-checking bench for the TDC hit control block
`timescale 1ns/1ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        start_in, stop1_in, stop2_in, ref_clk_in, meas_busy, meas_overflow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  lf;
    int          errors, cmp_count;
    // Design and reference source
    thcp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_in(start_in), .stop1_in(stop1_in), .stop2_in(stop2_in),
        .ref_clk_in(ref_clk_in), .meas_busy(meas_busy), .meas_overflow(meas_overflow));
    thcp_ref_src #(.HALF_NS(20)) ref_u (.ref_clk(ref_clk_in));
    // Clock generator
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A missing answer counts as a mismatch
        if (pready !== 1'b1) errors++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Compare seen against expected
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Two-cycle high pulse on a pin, rising gap plus two cycles after the last rise
    task automatic hit(input int w, input int gap);
        repeat (gap) @(posedge pclk);
        if (w == 0) start_in <= 1'b1; else if (w == 1) stop1_in <= 1'b1; else stop2_in <= 1'b1;
        repeat (2) @(posedge pclk);
        start_in <= 1'b0;
        stop1_in <= 1'b0;
        stop2_in <= 1'b0;
    endtask : hit
    // Verdict and end of run
    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, start_in, stop1_in, stop2_in} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 6'(2 * i), 32'h0);
            check("ctrl reset", rd, 32'h0);
        end
        apb(1'b1, thcp_pkg::IDX_CTRL2, 32'h21);
        apb(1'b0, thcp_pkg::IDX_CTRL2, 32'h0);
        check("ctrl2", rd, 32'h21);
        apb(1'b0, 6'h3f, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, thcp_pkg::IDX_CTRL6, 32'h70);
        apb(1'b1, thcp_pkg::IDX_INIT, 32'ha0);
        apb(1'b0, thcp_pkg::IDX_CTRL6, 32'h0);
        check("soft reset", rd, 32'h0);
        hit(0, 1);
        hit(1, 8);
        apb(1'b0, thcp_pkg::IDX_RAW0, 32'h0);
        check("plain hit", rd, 32'd10);
        apb(1'b1, thcp_pkg::IDX_INIT, 32'h01);
        hit(0, 1);
        repeat (2000) @(posedge pclk);
        check("overflow", {30'h0, meas_overflow, meas_busy}, 32'h2);
        apb(1'b1, thcp_pkg::IDX_INIT, 32'h01);
        apb(1'b1, thcp_pkg::IDX_CTRL6, 32'h20);
        hit(0, 1);
        hit(0, 3);
        hit(1, 8);
        hit(0, 3);
        hit(1, 8);
        apb(1'b0, thcp_pkg::IDX_RAW0, 32'h0);
        check("retrigger origin", rd, 32'd10);
        apb(1'b0, thcp_pkg::IDX_RAW0 + 6'h1, 32'h0);
        check("start after stop", rd, 32'd25);
        apb(1'b1, thcp_pkg::IDX_INIT, 32'h01);
        apb(1'b1, thcp_pkg::IDX_CTRL6, 32'h40);
        hit(0, 1);
        for (int i = 0; i < 4; i++) hit(1, 8);
        hit(2, 0);
        hit(1, 6);
        apb(1'b0, thcp_pkg::IDX_RAW0 + 6'h4, 32'h0);
        check("queued fifth", rd, 32'd50);
        apb(1'b0, thcp_pkg::IDX_STATUS, 32'h0);
        lf = rd[18:12];
        apb(1'b0, thcp_pkg::IDX_STATUS, 32'h0);
        check("noise held", {25'h0, rd[18:12]}, {25'h0, lf});
        // Noise stepped by the INIT write, here inside a running measurement
        apb(1'b1, thcp_pkg::IDX_INIT, 32'h08);
        apb(1'b0, thcp_pkg::IDX_STATUS, 32'h0);
        check("noise stepped", {31'h0, rd[18:12] != lf}, 32'h1);
        // Queuing cleared before the long range
        apb(1'b1, thcp_pkg::IDX_CTRL6, 32'h0);
        // Long range with the unused CTRL0 bit 5 also set
        apb(1'b1, thcp_pkg::IDX_CTRL0, 32'h30);
        apb(1'b1, thcp_pkg::IDX_INIT, 32'h01);
        hit(0, 1);
        hit(2, 8);
        hit(1, 40);
        repeat (20) @(posedge pclk);
        apb(1'b0, thcp_pkg::IDX_STATUS, 32'h0);
        check("long stop2 off", {28'h0, rd[11:8]}, 32'h0);
        check("long running", {29'h0, rd[2:0]}, 32'h3);
        print_verdict();
    end
endmodule : tb_top

// [thcp_checker.sv]
// Port assertions for the TDC hit control block
`timescale 1ns/1ps
module thcp_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and state
    input wire logic        start_in,
    input wire logic        meas_busy,
    input wire logic        meas_overflow
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase still waiting for its answer
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // Overflow raised at the end of a run
    sequence s_ovf;
        $rose(meas_overflow);
    endsequence
    a_ready_one_wait: assert property (s_access |=> pready)
        else $error("pready late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_needs_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not quiet");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_busy_after_start: assert property ($rose(meas_busy) |->
        ($past(start_in, 4) != $past(start_in, 5)) || ($past(start_in, 5) != $past(start_in, 6)))
        else $error("busy without start edge");
    a_ovf_ends_busy: assert property (s_ovf |-> ##[0:2] !meas_busy)
        else $error("busy after overflow");
    a_ovf_from_run: assert property (s_ovf |-> $past(meas_busy))
        else $error("overflow without run");
endmodule : thcp_checker
bind thcp_top thcp_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_in(start_in), .meas_busy(meas_busy), .meas_overflow(meas_overflow));

// [thcp_pkg.sv]
// Constants and types for the TDC hit control and predivider block
package thcp_pkg;
    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_CTRL0  = 6'h00;
    localparam logic [5:0] IDX_CTRL2  = 6'h02;
    localparam logic [5:0] IDX_CTRL4  = 6'h04;
    localparam logic [5:0] IDX_CTRL6  = 6'h06;
    localparam logic [5:0] IDX_INIT   = 6'h0b;
    localparam logic [5:0] IDX_STATUS = 6'h0c;
    localparam logic [5:0] IDX_RESULT = 6'h0d;
    localparam logic [5:0] IDX_RAW0   = 6'h10;
    localparam logic [5:0] IDX_CRS0   = 6'h18;
    // Control field positions
    localparam int CTRL0_EDGE_LO  = 0;
    localparam int CTRL0_RANGE    = 4;
    localparam int CTRL4_DIV_LO   = 5;
    localparam int CTRL6_NOISE    = 4;
    localparam int CTRL6_RETRIG   = 5;
    localparam int CTRL6_QUEUE    = 6;
    localparam int INIT_TDC       = 0;
    localparam int INIT_NOISE     = 3;
    localparam logic [3:0] POR_KEY = 4'ha;
    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [6:0] LFSR_SEED = 7'h01;
    // Timing
    localparam int CLK_MHZ       = 250;
    localparam int T_MIN_NS      = 3;
    localparam int T_MIN_RT_NS   = 6;
    localparam int T_DPR_NS      = 15;
    localparam int T_EXTRA_NS    = 25;
    localparam int R1_SPAN_NS    = 7600;
    localparam logic [15:0] MIN_CYC    = 16'((T_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] MIN_RT_CYC = 16'((T_MIN_RT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] DPR_CYC    = 16'((T_DPR_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] EXTRA_CYC  = 16'((T_EXTRA_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] R1_SPAN_CYC = 16'((R1_SPAN_NS * CLK_MHZ) / 1000);
    // Hit geometry
    localparam int HITS_CH  = 4;
    localparam int RAW_N    = 8;
    localparam logic [15:0] COARSE_MAX = 16'hffff;
    // Control register set
    typedef struct packed {
        logic [7:0] c6;
        logic [7:0] c4;
        logic [7:0] c2;
        logic [7:0] c0;
    } thcp_cfg_t;
    // Measurement states
    typedef enum logic [2:0] {ST_IDLE, ST_R1, ST_R2_FIRST, ST_R2_RUN, ST_DONE} thcp_state_t;
endpackage : thcp_pkg

// [thcp_ref_src.sv]
// Reference clock source at the far side of the timing pins
`timescale 1ns/1ps
module thcp_ref_src #(parameter int HALF_NS = 20) (
    // Reference clock out
    output logic ref_clk
);
    // Free running oscillator, phase unrelated to pclk
    initial begin
        ref_clk = 1'b0;
        #3;
        forever #HALF_NS ref_clk = ~ref_clk;
    end
endmodule : thcp_ref_src

// [thcp_top.sv]
// TDC hit control, retrigger, queuing, noise stepped by INIT writes and long-interval predivider
`timescale 1ns/1ps
module thcp_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timing pins
    input  wire logic        start_in,
    input  wire logic        stop1_in,
    input  wire logic        stop2_in,
    input  wire logic        ref_clk_in,
    // Measurement state
    output logic             meas_busy,
    output logic             meas_overflow
);
    // Register decode of a byte address into an index
    function automatic logic [5:0] reg_index(input logic [7:0] a);
        reg_index = a[7:2];
    endfunction : reg_index

    // Local copies of package constants, declared before any use
    localparam int RAW_N   = thcp_pkg::RAW_N;
    localparam int HITS_CH = thcp_pkg::HITS_CH;
    localparam logic [15:0] COARSE_MAX_L = thcp_pkg::COARSE_MAX;
    localparam thcp_pkg::thcp_state_t ST_IDLE     = thcp_pkg::ST_IDLE;
    localparam thcp_pkg::thcp_state_t ST_R1       = thcp_pkg::ST_R1;
    localparam thcp_pkg::thcp_state_t ST_R2_FIRST = thcp_pkg::ST_R2_FIRST;
    localparam thcp_pkg::thcp_state_t ST_R2_RUN   = thcp_pkg::ST_R2_RUN;
    localparam thcp_pkg::thcp_state_t ST_DONE     = thcp_pkg::ST_DONE;

    thcp_pkg::thcp_cfg_t   cfg_q;          // Control registers
    thcp_pkg::thcp_state_t st_q;           // Measurement state
    logic [3:0]  sync1_q, sync2_q, sync3_q; // Pin synchronisers
    logic [3:0]  lvl_q;                    // Filtered pin levels
    logic [3:0]  rise, fall;               // Level changes
    logic        start_ev, stop1_ev, stop2_ev, ref_rise;
    logic [6:0]  lfsr_q;                   // Noise generator
    logic [2:0]  off1, off2;               // Per-stop noise offsets
    logic [6:0]  div_cnt_q;                // Reference divider
    logic        cal_tick;                 // Calibration clock edge
    logic [15:0] cal_per_q, cal_cnt_q;     // Calibration period in cycles
    logic [15:0] t_q;                      // Cycles since start or last stop
    logic [15:0] gap1_q, gap2_q;           // Per-channel recovery
    logic [15:0] coarse_q;                 // Coarse period count
    logic [15:0] fine_q;                   // Running fine count
    logic        fine_on_q;                // Fine count in progress
    logic [3:0]  n1_q, n2_q;               // Hits per channel
    logic        stop_seen_q;              // Any stop accepted
    logic        ovf_q;                    // Overflow indication
    logic [15:0] raw_q [RAW_N];            // Raw values, never reset
    logic [15:0] crs_q [HITS_CH];          // Coarse count per stop
    logic [31:0] result_q;                 // Arithmetic result, never reset
    logic        soft_por, init_tdc, noise_step;
    logic        wr_en, rd_phase;
    logic        range2, retrig, queue, noise;
    logic        acc1, acc2;               // Stops accepted this cycle
    logic [15:0] min_cyc, r2_thr;
    logic [2:0]  idx1, idx2;               // Raw slots for this cycle
    logic [15:0] v1, v2;                   // Values to store
    logic [31:0] rd_data;
    logic        rd_err;

    // Mode decode
    assign range2 = cfg_q.c0[thcp_pkg::CTRL0_RANGE];
    assign queue  = cfg_q.c6[thcp_pkg::CTRL6_QUEUE] & ~range2;
    assign retrig = cfg_q.c6[thcp_pkg::CTRL6_RETRIG] & ~range2;
    assign noise  = cfg_q.c6[thcp_pkg::CTRL6_NOISE];

    // Bus strobes: a write lands at the edge where pready is seen high
    assign wr_en    = psel & penable & pready & pwrite;
    assign rd_phase = psel & penable & ~pready;
    assign soft_por = wr_en && reg_index(paddr) == thcp_pkg::IDX_INIT
                      && pwdata[7:4] == thcp_pkg::POR_KEY;
    assign init_tdc = wr_en && reg_index(paddr) == thcp_pkg::IDX_INIT
                      && pwdata[thcp_pkg::INIT_TDC];
    assign noise_step = wr_en && reg_index(paddr) == thcp_pkg::IDX_INIT
                        && pwdata[thcp_pkg::INIT_NOISE];

    // Three-stage synchronisers; a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else begin
            sync1_q <= {ref_clk_in, stop2_in, stop1_in, start_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Filtered level per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    lvl_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // Edge detection from agreed level against stored level
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_edge
            assign rise[g] = (sync2_q[g] == sync3_q[g]) & sync3_q[g] & ~lvl_q[g];
            assign fall[g] = (sync2_q[g] == sync3_q[g]) & ~sync3_q[g] & lvl_q[g];
        end
    endgenerate

    assign start_ev = cfg_q.c0[thcp_pkg::CTRL0_EDGE_LO]     ? fall[0] : rise[0];
    assign stop1_ev = cfg_q.c0[thcp_pkg::CTRL0_EDGE_LO + 1] ? fall[1] : rise[1];
    assign stop2_ev = cfg_q.c0[thcp_pkg::CTRL0_EDGE_LO + 2] ? fall[2] : rise[2];
    assign ref_rise = rise[3];

    // divide reference by power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 7'h00;
        end else if (soft_por) begin
            div_cnt_q <= 7'h00;
        end else if (ref_rise) begin
            div_cnt_q <= cal_tick ? 7'h00 : div_cnt_q + 7'h01;
        end
    end
    assign cal_tick = ref_rise &&
        ({1'b0, div_cnt_q} + 8'h01) >= (8'h01 << cfg_q.c4[thcp_pkg::CTRL4_DIV_LO +: 3]);

    // Calibration period measured in pclk cycles, used for the stop spacing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_q <= 16'h0000;
            cal_per_q <= 16'h0000;
        end else if (cal_tick) begin
            cal_cnt_q <= 16'h0001;
            cal_per_q <= cal_cnt_q;
        end else if (cal_cnt_q != COARSE_MAX_L) begin
            cal_cnt_q <= cal_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= thcp_pkg::LFSR_SEED;
        end else if (noise_step) begin
            lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
        end
    end
    assign off1 = noise ? lfsr_q[2:0] : 3'h0;
    assign off2 = noise ? {lfsr_q[4], lfsr_q[6], lfsr_q[3]} : 3'h0;

    // Stop acceptance
    // longer start gap on retrigger
    assign min_cyc = retrig ? thcp_pkg::MIN_RT_CYC : thcp_pkg::MIN_CYC;
    assign r2_thr  = cal_per_q + {1'b0, cal_per_q[15:1]} + thcp_pkg::EXTRA_CYC;
    always_comb begin
        acc1 = 1'b0;
        acc2 = 1'b0;
        if (st_q == ST_R1) begin
            acc1 = stop1_ev && t_q >= min_cyc && gap1_q >= thcp_pkg::DPR_CYC
                   && n1_q < (queue ? 4'(RAW_N) : 4'(HITS_CH));
            acc2 = stop2_ev && !queue && t_q >= min_cyc
                   && gap2_q >= thcp_pkg::DPR_CYC && n2_q < 4'(HITS_CH);
        end else if (st_q == ST_R2_RUN) begin
            acc1 = stop1_ev && !fine_on_q && t_q >= r2_thr && n1_q < 4'(HITS_CH);
        end
    end

    // Raw slot and value for each channel
    always_comb begin
        idx1 = n1_q[2:0];
        idx2 = 3'(HITS_CH) + n2_q[2:0];
        v1   = t_q + {13'h0000, off1};
        v2   = t_q + {13'h0000, off2};
    end

    // Measurement sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else if (soft_por || init_tdc) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE:     if (start_ev) st_q <= range2 ? ST_R2_FIRST : ST_R1;
                ST_R1: begin
                    if (t_q >= thcp_pkg::R1_SPAN_CYC) begin
                        st_q <= ST_DONE;
                    end else if ((n1_q + n2_q + {3'h0, acc1} + {3'h0, acc2}) >= 4'(RAW_N)) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_R2_FIRST: if (cal_tick) st_q <= ST_R2_RUN;
                ST_R2_RUN: begin
                    if (cal_tick && coarse_q == thcp_pkg::COARSE_MAX) begin
                        st_q <= ST_DONE;
                    end else if (cal_tick && fine_on_q && n1_q == 4'(HITS_CH)) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE:     st_q <= ST_DONE;
                default:     st_q <= ST_IDLE;
            endcase
        end
    end

    // Time base: cycles since start, or since the last stop in the long range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q <= 16'h0000;
        end else if (st_q == ST_IDLE || soft_por || init_tdc) begin
            t_q <= 16'h0001;
        end else if (st_q == ST_R1 && retrig && start_ev && !stop_seen_q) begin
            t_q <= 16'h0001;
        end else if (st_q == ST_R2_RUN && acc1) begin
            t_q <= 16'h0001;
        end else if (t_q != COARSE_MAX_L) begin
            t_q <= t_q + 16'h0001;
        end
    end

    // Channel recovery counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap1_q <= 16'h0000;
            gap2_q <= 16'h0000;
        end else begin
            gap1_q <= acc1 || st_q == ST_IDLE ? (st_q == ST_IDLE ? COARSE_MAX_L : 16'h0001)
                      : (gap1_q == COARSE_MAX_L ? gap1_q : gap1_q + 16'h0001);
            gap2_q <= acc2 || st_q == ST_IDLE ? (st_q == ST_IDLE ? COARSE_MAX_L : 16'h0001)
                      : (gap2_q == COARSE_MAX_L ? gap2_q : gap2_q + 16'h0001);
        end
    end

    // Hit counters and stop tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n1_q        <= 4'h0;
            n2_q        <= 4'h0;
            stop_seen_q <= 1'b0;
        end else if (st_q == ST_IDLE || soft_por || init_tdc) begin
            n1_q        <= 4'h0;
            n2_q        <= 4'h0;
            stop_seen_q <= 1'b0;
        end else begin
            if (acc1) n1_q <= n1_q + 4'h1;
            if (acc2) n2_q <= n2_q + 4'h1;
            if (acc1 || acc2) stop_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_q <= 16'h0000;
        end else if (st_q != ST_R2_RUN) begin
            coarse_q <= 16'h0000;
        end else if (cal_tick) begin
            coarse_q <= coarse_q + 16'h0001;
        end
    end

    // Fine counter: from start or stop up to the next calibration edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_q    <= 16'h0000;
            fine_on_q <= 1'b0;
        end else if (st_q == ST_IDLE) begin
            fine_q    <= 16'h0000;
            fine_on_q <= start_ev & range2;
        end else if (acc1 && st_q == ST_R2_RUN) begin
            fine_q    <= {13'h0000, off1};
            fine_on_q <= 1'b1;
        end else if (cal_tick) begin
            fine_on_q <= 1'b0;
        end else if (fine_on_q) begin
            fine_q    <= fine_q + 16'h0001;
        end
    end

    // Overflow flag: long range or short range span exceeded, each with no stop accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (soft_por || init_tdc || (st_q == ST_IDLE && start_ev)) begin
            ovf_q <= 1'b0;
        end else if (st_q == ST_R2_RUN && cal_tick && coarse_q == thcp_pkg::COARSE_MAX
                     && !stop_seen_q) begin
            ovf_q <= 1'b1;
        end else if (st_q == ST_R1 && t_q >= thcp_pkg::R1_SPAN_CYC && !stop_seen_q) begin
            ovf_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk) begin
        for (int i = 0; i < RAW_N; i++) begin
            if (st_q == ST_R1 && acc1 && idx1 == 3'(i)) begin
                raw_q[i] <= v1;
            end else if (st_q == ST_R1 && acc2 && idx2 == 3'(i)) begin
                raw_q[i] <= v2;
            // fine counts fill slots in order
            end else if (st_q == ST_R2_FIRST && cal_tick && i == 0) begin
                raw_q[i] <= fine_q;
            end else if (st_q == ST_R2_RUN && cal_tick && fine_on_q && n1_q == 4'(i)) begin
                raw_q[i] <= fine_q;
            end
        end
    end

    // Coarse count captured with each long-range stop
    always_ff @(posedge pclk) begin
        for (int i = 0; i < HITS_CH; i++) begin
            if (st_q == ST_R2_RUN && acc1 && n1_q == 4'(i)) begin
                crs_q[i] <= coarse_q;
            end
        end
    end

    function automatic logic [15:0] pick(input logic [3:0] s);
        pick = 16'h0000;
        if (s >= 4'h1 && s <= 4'h4) pick = raw_q[3'(s - 4'h1)];
        if (s >= 4'h9 && s <= 4'hc) pick = raw_q[3'(s - 4'h5)];
    endfunction : pick
    function automatic logic [15:0] pick_crs(input logic [3:0] s);
        pick_crs = 16'h0000;
        if (s >= 4'h2 && s <= 4'h4) pick_crs = crs_q[2'(s - 4'h2)];
        if (s == 4'h9) pick_crs = crs_q[3];
    endfunction : pick_crs

    // Fine counts are in clock cycles, so the calibration ratio is one period
    always_ff @(posedge pclk) begin
        if (range2) begin
            result_q <= 32'(pick_crs(cfg_q.c2[7:4])) * 32'(cal_per_q)
                        + 32'(pick(cfg_q.c2[3:0])) - 32'(pick(cfg_q.c2[7:4]));
        end else begin
            result_q <= {{16{1'b0}}, pick(cfg_q.c2[3:0]) - pick(cfg_q.c2[7:4])};
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= {4{thcp_pkg::CTRL_RST}};
        end else if (soft_por) begin
            cfg_q <= {4{thcp_pkg::CTRL_RST}};
        end else if (wr_en) begin
            case (reg_index(paddr))
                thcp_pkg::IDX_CTRL0: cfg_q.c0 <= pwdata[7:0];
                thcp_pkg::IDX_CTRL2: cfg_q.c2 <= pwdata[7:0];
                thcp_pkg::IDX_CTRL4: cfg_q.c4 <= pwdata[7:0];
                thcp_pkg::IDX_CTRL6: cfg_q.c6 <= pwdata[7:0];
                default:             cfg_q    <= cfg_q;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (reg_index(paddr))
            thcp_pkg::IDX_CTRL0:  rd_data = {24'h000000, cfg_q.c0};
            thcp_pkg::IDX_CTRL2:  rd_data = {24'h000000, cfg_q.c2};
            thcp_pkg::IDX_CTRL4:  rd_data = {24'h000000, cfg_q.c4};
            thcp_pkg::IDX_CTRL6:  rd_data = {24'h000000, cfg_q.c6};
            thcp_pkg::IDX_INIT:   rd_data = 32'h0000_0000;
            thcp_pkg::IDX_STATUS: rd_data = {13'h0000, lfsr_q, n2_q, n1_q, ovf_q, st_q};
            thcp_pkg::IDX_RESULT: rd_data = result_q;
            default: begin
                if (reg_index(paddr) >= thcp_pkg::IDX_RAW0
                    && reg_index(paddr) < thcp_pkg::IDX_RAW0 + 6'(RAW_N)) begin
                    rd_data = {16'h0000, raw_q[3'(reg_index(paddr) - thcp_pkg::IDX_RAW0)]};
                end else if (reg_index(paddr) >= thcp_pkg::IDX_CRS0
                    && reg_index(paddr) < thcp_pkg::IDX_CRS0 + 6'(HITS_CH)) begin
                    rd_data = {16'h0000, crs_q[2'(reg_index(paddr) - thcp_pkg::IDX_CRS0)]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // APB answer: one wait cycle, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_phase;
            prdata  <= rd_phase && !pwrite ? rd_data : 32'h0000_0000;
            pslverr <= rd_phase && rd_err;
        end
    end

    // Status pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_busy     <= 1'b0;
            meas_overflow <= 1'b0;
        end else begin
            meas_busy     <= st_q != ST_IDLE && st_q != ST_DONE;
            meas_overflow <= ovf_q;
        end
    end
endmodule : thcp_top
